// ### src/pcb_pkg.sv
// Shared constants for the printer command buffer
package pcb_pkg;
  localparam int PCB_NPOS = 20;
  localparam int PCB_CHAR_W = 7;
  localparam int PCB_PTR_W = 5;
  localparam int PCB_ST_W = 4;
  localparam int PCB_OP_W = 13;
  localparam int PCB_FUNC_N = 3;
  localparam int PCB_PIN_N = 5;
  // Bit positions of the sampled calculator pins
  localparam int PCB_PIN_PHI1 = 0;
  localparam int PCB_PIN_PHI2 = 1;
  localparam int PCB_PIN_INSTR = 2;
  localparam int PCB_PIN_DATA = 3;
  localparam int PCB_PIN_SYNC = 4;
  // State times
  localparam logic [3:0] PCB_ST_FIRST = 4'h3;
  localparam logic [3:0] PCB_ST_DATA_LAST = 4'h9;
  localparam logic [3:0] PCB_ST_LAST = 4'hF;
  localparam logic [3:0] PCB_ST_PULL = 4'h2;
  localparam logic [4:0] PCB_PTR_RIGHT = 5'h00;
  localparam logic [5:0] PCB_NPOS6 = 6'h14;
  localparam logic [6:0] PCB_BLANK = 7'h00;
  // Opcodes, state time 15 down to 3
  localparam logic [12:0] PCB_OP_LOAD = 13'h0A68;
  localparam logic [12:0] PCB_OP_FUNC = 13'h0A78;
  localparam logic [12:0] PCB_OP_CLEAR = 13'h0A88;
  localparam logic [12:0] PCB_OP_STEP = 13'h0A98;
  localparam logic [12:0] PCB_OP_PRINT = 13'h0AA8;
  localparam logic [12:0] PCB_OP_FEED = 13'h0AB8;
endpackage

// ### src/pcb_sync.sv
// Three-stage synchroniser for calculator pins
`timescale 1ns/1ns
module pcb_sync #(
  parameter int W = 1
) (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_s2,
  output logic [W-1:0] o_s3
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } pcb_sync_t;

  pcb_sync_t sync_q;
  pcb_sync_t sync_d;

  // Stage one is never read outside; it may be metastable
  always_comb begin
    sync_d = sync_q;
    if (i_ce) begin
      sync_d.s1 = i_async;
      sync_d.s2 = sync_q.s1;
      sync_d.s3 = sync_q.s2;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      sync_q <= '0;
    end else begin
      sync_q <= sync_d;
    end
  end

  assign o_s2 = sync_q.s2;
  assign o_s3 = sync_q.s3;
endmodule // pcb_sync

// ### src/pcb_top.sv
// Printer command decoder and twenty-position character buffer
`timescale 1ns/1ns
module pcb_top
  import pcb_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  input wire logic i_phi1,
  input wire logic i_phi2,
  input wire logic i_frame_sync,
  input wire logic i_instruction_serial_line,
  input wire logic i_character_data_line,
  input wire logic [20:0] i_func_chars,
  input wire logic i_mech_done,
  output logic o_shared_status_return_o,
  output logic o_shared_status_return_oe,
  output logic [6:0] o_func_code,
  output logic [139:0] o_line_chars,
  output logic o_print_start,
  output logic o_feed_start
);
  typedef struct packed {
    logic [PCB_PIN_N-1:0] pin;
    logic [PCB_ST_W-1:0] st;
    logic [PCB_OP_W-1:0] ir;
    logic [PCB_CHAR_W-1:0] dr;
    logic [PCB_NPOS-1:0][PCB_CHAR_W-1:0] mem;
    logic [PCB_PTR_W-1:0] ptr;
    logic active;
    logic arm;
    logic pull;
    logic print_go;
    logic feed_go;
  } pcb_state_t;

  pcb_state_t q;
  pcb_state_t d;
  logic [PCB_PIN_N-1:0] s2;
  logic [PCB_PIN_N-1:0] s3;
  logic ph1_rise;
  logic ph2_rise;
  logic sync_fall;
  logic dec_any;
  logic [PCB_OP_W-1:0] opcode;
  logic dec_load;
  logic dec_func;
  logic dec_clear;
  logic dec_step;
  logic dec_print;
  logic dec_feed;

  pcb_sync #(.W(PCB_PIN_N)) u_sync (
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst),
    .i_ce(i_ce),
    .i_async({i_frame_sync, i_character_data_line, i_instruction_serial_line, i_phi2, i_phi1}),
    .o_s2(s2),
    .o_s3(s3)
  );

  // Move k positions leftward, wrapping past the leftmost position
  function automatic logic [PCB_PTR_W-1:0] pos_add(input logic [PCB_PTR_W-1:0] p,
                                                   input logic [1:0] k);
    logic [5:0] s;
    s = {1'b0, p} + {4'h0, k};
    if (s >= PCB_NPOS6) begin
      s = s - PCB_NPOS6;
    end
    return s[PCB_PTR_W-1:0];
  endfunction

  always_comb begin
    d = q;
    d.print_go = 1'b0;
    d.feed_go = 1'b0;
    // A level change counts only once stages two and three agree
    for (int i = 0; i < PCB_PIN_N; i++) begin
      d.pin[i] = (s2[i] == s3[i]) ? s3[i] : q.pin[i];
    end
    ph1_rise = !q.pin[PCB_PIN_PHI1] && d.pin[PCB_PIN_PHI1];
    ph2_rise = !q.pin[PCB_PIN_PHI2] && d.pin[PCB_PIN_PHI2];
    sync_fall = q.pin[PCB_PIN_SYNC] && !d.pin[PCB_PIN_SYNC];
    opcode = {d.pin[PCB_PIN_INSTR], q.ir[PCB_OP_W-1:1]};
    dec_any = ph2_rise && (q.st == PCB_ST_LAST);
    dec_load = dec_any && (opcode == PCB_OP_LOAD);
    dec_func = dec_any && (opcode == PCB_OP_FUNC);
    dec_clear = dec_any && (opcode == PCB_OP_CLEAR);
    dec_step = dec_any && (opcode == PCB_OP_STEP);
    dec_print = dec_any && (opcode == PCB_OP_PRINT);
    dec_feed = dec_any && (opcode == PCB_OP_FEED);

    if (ph1_rise) begin
      d.st = q.st + 4'h1;
      if (d.st == PCB_ST_PULL && q.arm) begin
        d.pull = 1'b1;
        d.arm = 1'b0;
      end
    end
    if (sync_fall) begin
      d.st = '0;
      d.pull = 1'b0;
    end

    // Shifting runs every cycle whatever the command
    if (ph2_rise && q.st >= PCB_ST_FIRST) begin
      d.ir = opcode;
      if (q.st <= PCB_ST_DATA_LAST) begin
        d.dr = {d.pin[PCB_PIN_DATA], q.dr[PCB_CHAR_W-1:1]};
      end
    end

    // Mechanism finish clears first so a new start in the same cycle wins
    if (i_mech_done) begin
      d.active = 1'b0;
    end
    if (dec_clear) begin
      d.mem = '0;
      d.ptr = PCB_PTR_RIGHT;
    end
    if (dec_load) begin
      d.mem[q.ptr] = q.dr;
      d.ptr = pos_add(q.ptr, 2'd1);
    end
    if (dec_func) begin
      d.mem[q.ptr] = i_func_chars[6:0];
      d.mem[pos_add(q.ptr, 2'd1)] = i_func_chars[13:7];
      d.mem[pos_add(q.ptr, 2'd2)] = i_func_chars[20:14];
      d.ptr = pos_add(q.ptr, 2'd3);
    end
    if (dec_step) begin
      if (q.active) begin
        d.arm = 1'b1;
      end else begin
        d.ptr = pos_add(q.ptr, 2'd1);
      end
    end
    if (dec_print) begin
      d.active = 1'b1;
      d.print_go = 1'b1;
    end
    if (dec_feed) begin
      d.active = 1'b1;
      d.feed_go = 1'b1;
    end
    // Busy is released the moment the mechanism is idle
    if (!d.active) begin
      d.pull = 1'b0;
      d.arm = 1'b0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      q <= '0;
    end else if (i_ce) begin
      q <= d;
    end
  end

  assign o_shared_status_return_o = 1'b0;
  assign o_shared_status_return_oe = q.pull;
  assign o_func_code = q.dr;
  assign o_line_chars = q.mem;
  assign o_print_start = q.print_go;
  assign o_feed_start = q.feed_go;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);

  sequence step_in_print_s;
    dec_step && q.active && i_ce;
  endsequence
  // A pull left over from an earlier step may still stand here
  sequence armed_s;
    q.arm;
  endsequence

  decode_timing_a: assert property (dec_any |-> q.st == 4'hF && ph2_rise)
    else $error("decode outside state time fifteen");
  busy_float_a: assert property (o_shared_status_return_oe |-> q.active)
    else $error("busy driven while printer idle");
  busy_level_a: assert property (o_shared_status_return_oe |-> !o_shared_status_return_o)
    else $error("busy driven to wrong level");
  clear_blank_a: assert property (dec_clear && i_ce |=> q.mem == '0 && q.ptr == 5'h00)
    else $error("clear did not blank buffer");
  load_write_a: assert property (dec_load && i_ce |=> q.mem[$past(q.ptr)] == $past(q.dr))
    else $error("load did not store character");
  ptr_wrap_a: assert property (dec_load && i_ce && q.ptr == 5'h13 |=> q.ptr == 5'h00)
    else $error("pointer did not wrap");
  print_start_a: assert property (dec_print && i_ce |=> o_print_start && q.active)
    else $error("print did not start");
  feed_start_a: assert property (dec_feed && i_ce |=> o_feed_start && q.active)
    else $error("paper advance did not start");
  step_idle_a: assert property (dec_step && !q.active && i_ce |=>
      q.mem == $past(q.mem) && q.ptr == pos_add($past(q.ptr), 2'd1))
    else $error("idle step moved wrongly");
  step_arm_a: assert property (step_in_print_s ##1 q.active |-> armed_s)
    else $error("step in print did not arm busy");
  arm_pull_a: assert property (q.arm && ph1_rise && q.st == 4'h1 && !sync_fall
      && !i_mech_done && i_ce |=> o_shared_status_return_oe)
    else $error("armed busy not pulled at S2");
  ir_ignore_a: assert property (ph2_rise && q.st < PCB_ST_FIRST && i_ce
      |=> q.ir == $past(q.ir))
    else $error("instruction bit shifted before S3");
  busy_s2_a: assert property ($rose(o_shared_status_return_oe) |-> q.st == 4'h2)
    else $error("busy asserted outside S2");
  func_move_a: assert property (dec_func && i_ce |=> q.ptr == pos_add($past(q.ptr), 2'd3))
    else $error("function moved pointer wrongly");
endmodule // pcb_top

// ### testbench/pcb_calc_model.sv
// Calculator-side model: two-phase clocks, frame sync and serial lines
`timescale 1ns/1ns
module pcb_calc_model (
  input wire logic i_mclk,
  output logic o_phi1,
  output logic o_phi2,
  output logic o_sync,
  output logic o_instr,
  output logic o_data
);
  logic [12:0] op_q = 13'h0000;
  logic [6:0] data_q = 7'h00;
  logic [12:0] cur_op;
  logic [6:0] cur_data = 7'h00;
  logic req_q = 1'b0;
  logic take_q;
  event cyc_done;
  task automatic issue(input logic [12:0] op, input logic [6:0] data);
    op_q = op;
    data_q = data;
    req_q = 1'b1;
    @(cyc_done);
  endtask
  initial begin
    {o_phi1, o_phi2, o_sync, o_instr, o_data} = 5'h04;
    forever begin
      @(posedge i_mclk);
      #1;
      take_q = req_q;
      req_q = 1'b0;
      // Idle cycles send an opcode the printer must ignore
      cur_op = take_q ? op_q : 13'h0000;
      if (take_q) cur_data = data_q;
      for (int s = 0; s < 16; s++) begin
        if (s > 0) begin
          @(posedge i_mclk);
          #1;
        end
        o_phi1 = 1'b1;
        o_sync = (s == 15);
        o_instr = (s < 3) ? 1'b1 : cur_op[s-3];
        o_data = (s >= 3 && s <= 9) ? cur_data[s-3] : s[0];
        repeat (2) @(posedge i_mclk);
        #1;
        o_phi1 = 1'b0;
        repeat (2) @(posedge i_mclk);
        #1;
        o_phi2 = 1'b1;
        repeat (3) @(posedge i_mclk);
        #1;
        o_phi2 = 1'b0;
      end
      if (take_q) ->cyc_done;
    end
  end
endmodule // pcb_calc_model

// ### testbench/pcb_top_bench.sv
// Self-checking bench for the printer command buffer
`timescale 1ns/1ns
module pcb_top_bench;
  import pcb_pkg::*;
  logic i_mclk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_mech_done = 1'b0;
  logic phi1, phi2, sync, instr, data, busy_o, busy_oe, print_start, feed_start;
  logic [6:0] func_code;
  logic [20:0] fchars;
  logic [139:0] line, exp_q;
  int fail_count = 0;
  int compares = 0;
  int n_print = 0;
  int n_feed = 0;
  // Calculator pull-up: released line reads idle
  wire busy_line_n = busy_oe ? busy_o : 1'b1;
  assign fchars = {func_code ^ 7'h03, func_code ^ 7'h02, func_code ^ 7'h01};
  always #4 i_mclk = ~i_mclk;
  // Counted on the falling edge, clear of the edge that launches the pulse
  always @(negedge i_mclk) begin
    n_print += (print_start === 1'b1);
    n_feed += (feed_start === 1'b1);
  end
  pcb_calc_model u_pcb_calc_model (.i_mclk(i_mclk), .o_phi1(phi1), .o_phi2(phi2),
    .o_sync(sync), .o_instr(instr), .o_data(data));
  pcb_top u_pcb_top (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_ce(1'b1), .i_phi1(phi1),
    .i_phi2(phi2), .i_frame_sync(sync), .i_instruction_serial_line(instr),
    .i_character_data_line(data), .i_func_chars(fchars), .i_mech_done(i_mech_done),
    .o_shared_status_return_o(busy_o), .o_shared_status_return_oe(busy_oe),
    .o_func_code(func_code), .o_line_chars(line), .o_print_start(print_start),
    .o_feed_start(feed_start));
  task automatic check(input logic [139:0] got, input logic [139:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic [12:0] op, input logic [6:0] d);
    u_pcb_calc_model.issue(op, d);
    repeat (4) @(posedge i_mclk);
    #1;
  endtask
  task automatic mech();
    i_mech_done = 1'b1;
    @(posedge i_mclk);
    #1;
    i_mech_done = 1'b0;
  endtask
  // Step, then watch the busy line through the following cycle
  task automatic poll(input logic act);
    u_pcb_calc_model.issue(PCB_OP_STEP, 7'h00);
    repeat (12) @(posedge i_mclk);
    #1;
    check(140'(busy_line_n), 140'h1);
    repeat (14) @(posedge i_mclk);
    #1;
    check(140'(busy_line_n), 140'(!act));
    repeat (112) @(posedge i_mclk);
    #1;
    check(140'(busy_line_n), 140'h1);
  endtask
  task automatic t_load_step();
    cmd(PCB_OP_LOAD, 7'h15);
    cmd(PCB_OP_CLEAR, 7'h7F);
    exp_q = '0;
    check(line, exp_q);
    cmd(PCB_OP_LOAD, 7'h11);
    cmd(PCB_OP_LOAD, 7'h22);
    cmd(PCB_OP_STEP, 7'h33);
    cmd(13'h0A58, 7'h44);
    cmd(PCB_OP_LOAD, 7'h55);
    exp_q[27:0] = {7'h55, 7'h00, 7'h22, 7'h11};
    check(line, exp_q);
  endtask
  task automatic t_wrap();
    cmd(PCB_OP_CLEAR, 7'h00);
    for (int i = 1; i <= 21; i++) cmd(PCB_OP_LOAD, 7'(i));
    for (int i = 0; i < 20; i++) exp_q[i*7 +: 7] = 7'(i + 1);
    exp_q[6:0] = 7'h15;
    check(line, exp_q);
    cmd(PCB_OP_LOAD, 7'h7E);
    exp_q[13:7] = 7'h7E;
    check(line, exp_q);
  endtask
  task automatic t_func();
    cmd(PCB_OP_CLEAR, 7'h00);
    cmd(PCB_OP_LOAD, 7'h01);
    cmd(PCB_OP_FUNC, 7'h2A);
    cmd(PCB_OP_LOAD, 7'h05);
    exp_q = '0;
    exp_q[34:0] = {7'h05, 7'h29, 7'h28, 7'h2B, 7'h01};
    check(line, exp_q);
    check(140'(func_code), 140'h05);
  endtask
  task automatic t_busy();
    int p0;
    int f0;
    p0 = n_print;
    f0 = n_feed;
    cmd(PCB_OP_CLEAR, 7'h00);
    cmd(PCB_OP_PRINT, 7'h00);
    check(140'(n_print), 140'(p0 + 1));
    poll(1'b1);
    poll(1'b1);
    mech();
    poll(1'b0);
    cmd(PCB_OP_FEED, 7'h00);
    check(140'(n_feed), 140'(f0 + 1));
    poll(1'b1);
    mech();
    cmd(PCB_OP_LOAD, 7'h66);
    exp_q = '0;
    exp_q[13:7] = 7'h66;
    check(line, exp_q);
  endtask
  task automatic stop_test();
    if (fail_count == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge i_mclk);
    #1;
    i_sys_rst = 1'b0;
    t_load_step();
    t_wrap();
    t_func();
    t_busy();
    stop_test();
  end
  // About 90 instruction cycles expected; generous margin
  initial begin
    #300000;
    fail_count++;
    stop_test();
  end
endmodule // pcb_top_bench
